// ---- aef_flag_bus.sv ----
// Purpose: decides when this device drives the shared almost-empty bus
// Assumes: chain partners, host strobes and flags all run on mclk
// Notes:   bus pins are split into value and enable; wiring resolves them
//
// Contract
// - flag mode low at reset selects direct addressed ownership for good
// - flag mode high at reset selects polled ring ownership for good
// - direct: strobe with address top bits equal to identity takes bus
// - newly selected device shows its flags one cycle after selection
// - bus bit and active flag both lag the queue flags by one cycle
// - a new direct selection is accepted every cycle
// - only leader starts polling; others wait for the token
// - leader in polled mode drives bus on first edge after reset release
// - leader in polled mode pulses poll sync one cycle whenever it owns the bus
// - token goes out during ownership; receiver owns next cycle
// - token from last device returns ownership to the leader
// - in polled mode token output high exactly in the cycle the device owns bus; always low in direct mode
// - only the owner drives the bus; others float it
// - queues one to four map to bus bits zero to three
`timescale 1ns/10ps
module aef_flag_bus (
	// clock and master reset
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	// straps and chain
	input  wire logic                        flag_mode_select,
	input  wire logic                        chain_leader_select,
	input  wire logic [aef_pkg::ID_W-1:0]    device_identity_inputs,
	input  wire logic                        token_in,
	output logic                             token_out,
	output logic                             poll_sync_pulse,
	// host read port
	input  wire logic [aef_pkg::ADDR_W-1:0]  read_port_address,
	input  wire logic                        almost_empty_bus_strobe,
	// queue flags
	input  wire logic [aef_pkg::FLAG_W-1:0]  queue_almost_empty,
	input  wire logic [1:0]                  active_queue,
	output logic                             active_almost_empty_flag,
	// shared status bus
	output logic [aef_pkg::FLAG_W-1:0]       almost_empty_status_bus,
	output logic                             almost_empty_status_bus_oe,
	// register port
	input  wire logic [aef_pkg::REG_AW-1:0]  reg_addr,
	input  wire logic [31:0]                 reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic [31:0]                      reg_rdata,
	output logic                             irq
);
	import aef_pkg::*;

	aef_phase_t               phase_reg, phase_next;
	aef_mode_t                mode_reg, mode_next;
	logic                     leader_reg, leader_next;
	logic                     own_reg, own_next;
	logic                     sync_reg, sync_next;
	logic                     tok_reg, tok_next;
	logic [FLAG_W-1:0]        bus_reg, bus_next;
	logic                     act_reg, act_next;
	logic [EVT_W-1:0]         status_reg, status_next;
	logic [EVT_W-1:0]         mask_reg, mask_next;
	logic [31:0]              rdata_reg, rdata_next;
	logic                     irq_reg, irq_next;
	logic                     id_match;
	logic [EVT_W-1:0]         evt;

	assign id_match = read_port_address[ADDR_ID_HI:ADDR_ID_LO] == device_identity_inputs;

	// ownership: straps are caught on the first edge after release
	always_comb begin
		phase_next  = phase_reg;
		mode_next   = mode_reg;
		leader_next = leader_reg;
		own_next    = own_reg;
		sync_next   = 1'b0;
		unique case (phase_reg)
			PH_WAIT: begin
				phase_next  = PH_RUN;
				mode_next   = flag_mode_select ? MODE_POLLED : MODE_DIRECT;
				leader_next = chain_leader_select;
				// polled leader grabs the bus at once, the rest wait for token or strobe
				own_next    = flag_mode_select & chain_leader_select;
				sync_next   = flag_mode_select & chain_leader_select;
			end
			PH_RUN: begin
				if (mode_reg == MODE_POLLED) begin
					// ring closes on the leader, so it comes round again
					own_next  = token_in;
					sync_next = token_in & leader_reg;
				end else if (almost_empty_bus_strobe) begin
					own_next = id_match;
				end
			end
			default: begin
				phase_next = PH_WAIT;
				own_next   = 1'b0;
			end
		endcase
		// token output gets its own flop so the pin never sees a gate glitch
		tok_next = own_next & (mode_next == MODE_POLLED);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg  <= PH_WAIT;
			mode_reg   <= MODE_DIRECT;
			leader_reg <= 1'b0;
			own_reg    <= 1'b0;
			sync_reg   <= 1'b0;
			tok_reg    <= 1'b0;
		end else begin
			phase_reg  <= phase_next;
			mode_reg   <= mode_next;
			leader_reg <= leader_next;
			own_reg    <= own_next;
			sync_reg   <= sync_next;
			tok_reg    <= tok_next;
		end
	end

	// flag values: one register stage, so a bit may trail the queue
	always_comb begin
		bus_next = queue_almost_empty;
		act_next = queue_almost_empty[active_queue];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_reg <= FLAG_RST;
			act_reg <= 1'b1;
		end else begin
			bus_reg <= bus_next;
			act_reg <= act_next;
		end
	end

	// events: edges of ownership and the leader's round marker
	assign evt = {sync_next, own_reg & ~own_next, ~own_reg & own_next};

	// registers: read clears status, a new event wins over the clear
	always_comb begin
		status_next = status_reg;
		mask_next   = mask_reg;
		rdata_next  = 32'h0;
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_STATUS: begin
					rdata_next[EVT_W-1:0] = status_reg;
					status_next           = STATUS_RST;
				end
				OFS_MASK: begin
					rdata_next[EVT_W-1:0] = mask_reg;
				end
				OFS_INFO: begin
					rdata_next[INF_MODE]   = mode_reg;
					rdata_next[INF_LEADER] = leader_reg;
					rdata_next[INF_OWNER]  = own_reg;
					rdata_next[INF_ID_LO +: ID_W] = device_identity_inputs;
				end
				default: rdata_next = 32'h0; // unmapped reads zero
			endcase
		end
		if (reg_wr && reg_addr == OFS_MASK) begin
			mask_next = reg_wdata[EVT_W-1:0];
		end
		status_next = status_next | evt;
		irq_next    = |(status_next & mask_next);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= STATUS_RST;
			mask_reg   <= MASK_RST;
			rdata_reg  <= 32'h0;
			irq_reg    <= 1'b0;
		end else begin
			status_reg <= status_next;
			mask_reg   <= mask_next;
			rdata_reg  <= rdata_next;
			irq_reg    <= irq_next;
		end
	end

	// outputs straight from flops; enable only while owning
	assign almost_empty_status_bus    = bus_reg;
	assign almost_empty_status_bus_oe = own_reg;
	assign token_out                  = tok_reg;
	assign poll_sync_pulse            = sync_reg;
	assign active_almost_empty_flag   = act_reg;
	assign reg_rdata                  = rdata_reg;
	assign irq                        = irq_reg;

	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	AST_DIRECT_TAKE: assert property (
		phase_reg == PH_RUN && mode_reg == MODE_DIRECT
		&& almost_empty_bus_strobe && id_match |=> almost_empty_status_bus_oe
		&& almost_empty_status_bus == $past(queue_almost_empty))
		else $error("direct select did not take the bus");
	AST_DIRECT_DROP: assert property (
		phase_reg == PH_RUN && mode_reg == MODE_DIRECT
		&& almost_empty_bus_strobe && !id_match |=> !almost_empty_status_bus_oe)
		else $error("owner kept bus after foreign strobe");
	AST_DIRECT_HOLD: assert property (
		phase_reg == PH_RUN && mode_reg == MODE_DIRECT
		&& !almost_empty_bus_strobe |=> $stable(almost_empty_status_bus_oe))
		else $error("ownership changed without strobe");
	AST_POLL_PASS: assert property (
		phase_reg == PH_RUN && mode_reg == MODE_POLLED
		|-> ##1 (almost_empty_status_bus_oe == $past(token_in)))
		else $error("token did not hand over the bus");
	AST_TOKEN_OWN: assert property (
		mode_reg == MODE_POLLED && phase_reg == PH_RUN
		|-> token_out == almost_empty_status_bus_oe)
		else $error("token output differs from ownership");
	AST_SYNC_LEADER: assert property (
		poll_sync_pulse |-> leader_reg && token_out)
		else $error("sync pulse without leader owning");
	AST_LEADER_FIRST: assert property (
		rst_n && phase_reg == PH_WAIT && flag_mode_select && chain_leader_select
		|=> almost_empty_status_bus_oe && poll_sync_pulse)
		else $error("leader missed first edge");
	AST_OTHER_WAIT: assert property (
		rst_n && phase_reg == PH_WAIT && !chain_leader_select
		|=> !almost_empty_status_bus_oe)
		else $error("non-leader drove bus before token");
	AST_MODE_KEPT: assert property (
		phase_reg == PH_RUN |=> $stable(mode_reg))
		else $error("mode changed after reset");
	AST_MAP: assert property (
		rst_n |=> almost_empty_status_bus == $past(queue_almost_empty))
		else $error("bus bits out of queue order");
	AST_IRQ: assert property (
		irq == |(status_reg & mask_reg))
		else $error("interrupt disagrees with status and mask");

	// start phase: reset releases on an edge, so antecedents wait for rst_n
	AST_MODE_FROM_STRAP: assert property (
		rst_n && phase_reg == PH_WAIT |=> (mode_reg == MODE_POLLED) == $past(flag_mode_select))
		else $error("mode does not match the strap");
	AST_WAIT_ONCE: assert property (
		rst_n && phase_reg == PH_WAIT |=> phase_reg == PH_RUN)
		else $error("start phase lasted more than one edge");
	AST_OE_START: assert property (
		rst_n && phase_reg == PH_WAIT |-> !almost_empty_status_bus_oe)
		else $error("bus driven before straps were caught");
	AST_LEADER_KEPT: assert property (
		phase_reg == PH_RUN |=> $stable(leader_reg))
		else $error("leader strap changed after reset");

	// direct mode
	AST_DIRECT_QUIET: assert property (
		phase_reg == PH_RUN && mode_reg == MODE_DIRECT |-> !token_out && !poll_sync_pulse)
		else $error("ring outputs active in direct mode");
	AST_BACK_TO_BACK: assert property (
		phase_reg == PH_RUN && mode_reg == MODE_DIRECT && almost_empty_bus_strobe
		&& id_match ##1 almost_empty_bus_strobe && !id_match
		|=> !almost_empty_status_bus_oe)
		else $error("second selection in a row was not taken");
	AST_ACTIVE_FLAG: assert property (
		rst_n |=> active_almost_empty_flag == $past(queue_almost_empty[active_queue]))
		else $error("active flag does not follow the active queue");

	// polled mode
	AST_POLL_NO_STROBE: assert property (
		phase_reg == PH_RUN && mode_reg == MODE_POLLED && !token_in
		|=> !almost_empty_status_bus_oe)
		else $error("polled device took bus without token");
	AST_POLL_ONE_CYCLE: assert property (
		phase_reg == PH_RUN && mode_reg == MODE_POLLED && !token_in |=> !token_out)
		else $error("token output outlived ownership");
	AST_TOKEN_TAKE: assert property (
		phase_reg == PH_RUN && mode_reg == MODE_POLLED && token_in |=> token_out)
		else $error("token arrival did not give ownership");
	AST_LEADER_AGAIN: assert property (
		phase_reg == PH_RUN && mode_reg == MODE_POLLED && leader_reg && token_in
		|=> poll_sync_pulse && almost_empty_status_bus_oe)
		else $error("returning token did not restart the round");
	AST_SYNC_POLLED: assert property (
		poll_sync_pulse |-> mode_reg == MODE_POLLED)
		else $error("sync pulse in direct mode");
	AST_BUS_OWNER_ONLY: assert property (
		almost_empty_status_bus_oe |-> mode_reg == MODE_DIRECT || token_out)
		else $error("polled device drove bus without token output");

	// register side: a new event beats the clearing read
	AST_SET_WINS: assert property (
		rst_n && evt != 3'h0 |=> (status_reg & $past(evt)) == $past(evt))
		else $error("event lost against a status read");
	AST_READ_CLEARS: assert property (
		rst_n && reg_rd && reg_addr == OFS_STATUS && evt == 3'h0
		|=> status_reg == STATUS_RST)
		else $error("status read did not clear");
	AST_RDATA_IDLE: assert property (
		!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data stood outside its cycle");
	AST_MASK_WRITE: assert property (
		rst_n && reg_wr && reg_addr == OFS_MASK
		|=> mask_reg == $past(reg_wdata[EVT_W-1:0]))
		else $error("mask write did not land");
	AST_INFO_ID: assert property (
		reg_rd && reg_addr == OFS_INFO
		|=> reg_rdata[INF_ID_LO +: ID_W] == $past(device_identity_inputs))
		else $error("identity field wrong in info read");

	COV_DIRECT: cover property (
		almost_empty_bus_strobe && id_match ##1 almost_empty_bus_strobe && !id_match);
	COV_ROUND: cover property (poll_sync_pulse ##1 !poll_sync_pulse [*2] ##1 poll_sync_pulse);
	COV_PASS: cover property (token_out ##1 !token_out && token_in);
	COV_LEADER_START: cover property (rst_n && phase_reg == PH_WAIT ##1 poll_sync_pulse);
	COV_SET_CLEAR: cover property (irq ##1 reg_rd && reg_addr == OFS_STATUS ##1 !irq);
endmodule : aef_flag_bus

// ---- aef_pkg.sv ----
// Purpose: constants for the almost-empty status bus owner logic
// Assumes: one read clock shared by every device of the chain
// Notes:   register offsets are byte addresses on the plain port
package aef_pkg;
	// widths
	localparam int unsigned ADDR_W   = 6;
	localparam int unsigned ID_W     = 3;
	localparam int unsigned FLAG_W   = 4;
	localparam int unsigned REG_AW   = 4;
	localparam int unsigned EVT_W    = 3;
	// identity field in the read-port address
	localparam int unsigned ADDR_ID_HI = 5;
	localparam int unsigned ADDR_ID_LO = 3;
	// register offsets
	localparam logic [3:0] OFS_STATUS = 4'h0;
	localparam logic [3:0] OFS_MASK   = 4'h4;
	localparam logic [3:0] OFS_INFO   = 4'h8;
	// event bit positions in status and mask
	localparam int unsigned EVT_GAIN  = 0;
	localparam int unsigned EVT_LOSE  = 1;
	localparam int unsigned EVT_ROUND = 2;
	// info field positions
	localparam int unsigned INF_MODE   = 0;
	localparam int unsigned INF_LEADER = 1;
	localparam int unsigned INF_OWNER  = 2;
	localparam int unsigned INF_ID_LO  = 4;
	// reset values
	localparam logic [2:0]  MASK_RST   = 3'h0;
	localparam logic [2:0]  STATUS_RST = 3'h0;
	localparam logic [3:0]  FLAG_RST   = 4'hf;
	// bus ownership mode, latched once after reset
	typedef enum logic {MODE_DIRECT = 1'b0, MODE_POLLED = 1'b1} aef_mode_t;
	// run phase: waiting for the first edge after reset, then running
	typedef enum logic [1:0] {PH_WAIT = 2'b00, PH_RUN = 2'b01} aef_phase_t;
endpackage : aef_pkg

// ---- aef_ring_model.sv ----
// Purpose: other devices of the poll ring, seen from the leader
// Assumes: the whole ring runs on mclk
// Notes:   each stage owns the shared bus for one cycle
`timescale 1ns/10ps
module aef_ring_model #(
	parameter int unsigned N_OTHERS = 2
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// token ring
	input  wire logic token_from_dut,
	output logic      token_to_dut,
	output logic      others_oe
);
	logic [N_OTHERS-1:0] own_reg;
	logic [N_OTHERS-1:0] own_next;
	// token moves one device a cycle; a stage without it stays off the bus
	always_comb begin
		own_next = {own_reg[N_OTHERS-2:0], token_from_dut};
	end
	// ownership flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			own_reg <= {N_OTHERS{1'b0}};
		end else begin
			own_reg <= own_next;
		end
	end
	// last stage hands back; token out is high while owning
	assign token_to_dut = own_reg[N_OTHERS-1];
	assign others_oe    = |own_reg;
endmodule : aef_ring_model

// ---- aef_flag_bus_tb_top.sv ----
// Purpose: self-checking bench for the almost-empty bus owner
// Assumes: host, ring and device share mclk
// Notes:   identity strapped to 5; ring of two other devices
`timescale 1ns/10ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end end
module aef_flag_bus_tb_top;
	import aef_pkg::*;
	logic        mclk  = 1'b0;
	logic        rst_n = 1'b0;
	logic        fm    = 1'b0;
	logic        lead  = 1'b0;
	logic        stb   = 1'b0;
	logic        rd    = 1'b0;
	logic        wr    = 1'b0;
	logic [5:0]  addr  = 6'h00;
	logic [3:0]  qae   = 4'hf;
	logic [1:0]  aq    = 2'h0;
	logic [3:0]  radr  = 4'h0;
	logic [31:0] wdat  = 32'h0;
	logic        tok_in, tok_out, sync, act, oe, irq, oth;
	logic [3:0]  bus;
	logic [31:0] rdat;
	wire  [3:0]  ae_bus;
	int          errors    = 0;
	int          tests_run = 0;
	int          n;
	always #10 mclk = ~mclk;
	// shared bus: only an owner drives it, otherwise it floats
	assign ae_bus = oe ? bus : (oth ? 4'h0 : 4'hz);
	aef_flag_bus u_aef_flag_bus (.mclk(mclk), .rst_n(rst_n), .flag_mode_select(fm),
		.chain_leader_select(lead), .device_identity_inputs(3'h5), .token_in(tok_in),
		.token_out(tok_out), .poll_sync_pulse(sync), .read_port_address(addr),
		.almost_empty_bus_strobe(stb), .queue_almost_empty(qae), .active_queue(aq),
		.active_almost_empty_flag(act), .almost_empty_status_bus(bus),
		.almost_empty_status_bus_oe(oe), .reg_addr(radr), .reg_wdata(wdat),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .irq(irq));
	aef_ring_model u_aef_ring_model (.mclk(mclk), .rst_n(rst_n),
		.token_from_dut(tok_out), .token_to_dut(tok_in), .others_oe(oth));
	task automatic complete_run();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	// reset with straps, leaves us after the strap capture edge
	task automatic do_reset(input logic m, input logic l);
		@(posedge mclk);
		rst_n <= 1'b0;
		fm    <= m;
		lead  <= l;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		`CHK("oe_rst", 1'b0, oe)
		`CHK("tok_rst", 1'b0, tok_out | sync)
		`CHK("act_rst", 1'b1, act)
		@(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		@(negedge mclk);
	endtask : do_reset
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		wr   <= 1'b1;
		radr <= a;
		wdat <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : reg_write
	// read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a, input logic [31:0] e, input string s);
		@(posedge mclk);
		rd   <= 1'b1;
		radr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		`CHK(s, e, rdat)
	endtask : reg_read
	initial begin
		// direct mode: select us, then another device on the next cycle
		do_reset(1'b0, 1'b0);
		reg_write(OFS_MASK, 32'h3);
		@(posedge mclk);
		stb  <= 1'b1; // the active queue select moves to queue 2 together with the strobe
		addr <= {3'h5, 3'h2};
		qae  <= 4'ha;
		aq   <= 2'h2;
		@(posedge mclk);
		addr <= {3'h2, 3'h0};
		qae  <= 4'h6;
		@(negedge mclk);
		`CHK("oe_sel", 1'b1, oe)
		`CHK("bus_sel", 4'ha, ae_bus)
		`CHK("act_a", 1'b0, act)
		@(posedge mclk);
		stb <= 1'b0;
		@(negedge mclk);
		`CHK("oe_lose", 1'b0, oe)
		`CHK("float", 4'hz, ae_bus)
		`CHK("act_b", 1'b1, act)
		repeat (2) @(negedge mclk);
		`CHK("irq_set", 1'b1, irq)
		reg_read(OFS_STATUS, 32'h3, "status");
		reg_read(OFS_STATUS, 32'h0, "status_clr");
		`CHK("irq_clr", 1'b0, irq)
		reg_read(OFS_INFO, 32'h50, "info");
		reg_read(4'hc, 32'h0, "unmapped");
		reg_read(OFS_MASK, 32'h3, "mask");
		// polled leader: owns first cycle, token comes back round the ring
		do_reset(1'b1, 1'b1);
		`CHK("oe_first", 1'b1, oe)
		`CHK("tok_first", 1'b1, tok_out)
		`CHK("sync_first", 1'b1, sync)
		n = 0;
		do begin
			@(negedge mclk);
			n++;
			`CHK("overlap", 1'b0, oe & oth)
			`CHK("sync_oe", oe, sync)
			`CHK("tok_oe", oe, tok_out)
		end while (oe !== 1'b1 && n < 10);
		`CHK("ring_len", 3, n)
		if (n >= 10) begin
			complete_run();
		end
		// gained, lost and round marker all seen; mask is back at zero
		reg_read(OFS_STATUS, 32'h7, "status_poll");
		`CHK("irq_masked", 1'b0, irq)
		// polled non-leader: strobes ignored, no token so never drives
		do_reset(1'b1, 1'b0);
		@(posedge mclk);
		stb  <= 1'b1;
		addr <= {3'h5, 3'h0};
		@(posedge mclk);
		stb <= 1'b0;
		repeat (3) begin
			@(negedge mclk);
			`CHK("idle", 1'b0, oe | tok_out | sync)
		end
		complete_run();
	end
endmodule : aef_flag_bus_tb_top
